// File: core/mnu_defs.svh
// Purpose: named constants for the menu mode controller
// Assumes: 16-bit cpu address, 8-bit data, 200 MHz system clock
// Notes:   offsets are byte addresses on the host cpu bus
`ifndef MNU_DEFS_SVH
`define MNU_DEFS_SVH

// register addresses
`define MNU_CFG_PAGE     12'hD0F
`define MNU_REG_CART     16'hD0F0
`define MNU_REG_PORT     16'hD0F1
`define MNU_REG_RAMEXP   16'hD0F5
`define MNU_REG_EXTRA    16'hD0FA
`define MNU_REG_STATUS   16'hD0FD
`define MNU_REG_CMD      16'hD0FE
`define MNU_REG_CFGDIS   16'hD0FF

// command and read values
`define MNU_CMD_MENU     8'h20
`define MNU_CMD_RST_A    8'hA5
`define MNU_CMD_RST_B    8'hA6
`define MNU_RTI_OP       8'h40
`define MNU_READ_IDLE    8'hFF
`define MNU_CORE_VER     8'h5A
`define MNU_CART_OFF     8'h00

// field positions
`define MNU_EXTRA_BIT    5
`define MNU_MEMCARD_BIT  2
`define MNU_RAMEXP_BIT   7
`define MNU_STAT_MENU    0
`define MNU_STAT_CFG     1
`define MNU_STAT_EXTRA   2

// memory map
`define MNU_EXTRA_PAGE   8'hD7
`define MNU_IO_NIB       4'hD
`define MNU_C_NIB        4'hC
`define MNU_CHAR_NIB_LO  4'h1
`define MNU_CHAR_NIB_HI  4'h9
`define MNU_CHAR_BANK    8'h1D
`define MNU_SUBST_BASE   8'h20
`define MNU_KEEP_IDX     3'h6

// freeze hold timing
`define MNU_HOLD_MS      700
`define MNU_CLK_KHZ      200000
`define MNU_HOLD_CYC     (`MNU_HOLD_MS * `MNU_CLK_KHZ)
`define MNU_HOLD_W       28

`endif

// File: core/mnu_pkg.sv
// Purpose: shared types of the menu mode controller
// Assumes: used together with mnu_defs.svh
// Notes:   types only, constants live in the header
package mnu_pkg;

    // menu mode state
    typedef enum logic {
        MNU_OFF = 1'b0,
        MNU_ON  = 1'b1
    } mnu_state_e;

    // target of a cpu access
    typedef enum logic [1:0] {
        MNU_SEL_NORM  = 2'b00,
        MNU_SEL_SUBST = 2'b01,
        MNU_SEL_IO    = 2'b10,
        MNU_SEL_EXTRA = 2'b11
    } mnu_sel_e;

endpackage

// File: core/mnu_hold_timer.sv
// Purpose: freeze button hold timer, one pulse per long press
// Assumes: button pin is asynchronous and active low
// Notes:   fires when held strictly longer than HOLD_CYCLES
`timescale 1ns/1ps
`include "mnu_defs.svh"
module mnu_hold_timer #(
    parameter int unsigned HOLD_CYCLES = `MNU_HOLD_CYC
) (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    // button and trigger
    input  wire logic i_freeze_n,
    output logic      o_fire
);

    localparam logic [`MNU_HOLD_W-1:0] HOLD_LIM = `MNU_HOLD_W'(HOLD_CYCLES);

    logic                   sync1_q;
    logic                   sync2_q;
    logic [`MNU_HOLD_W-1:0] cnt_q;
    logic [`MNU_HOLD_W-1:0] cnt_d;
    logic                   done_q;
    logic                   done_d;
    logic                   fire_q;
    logic                   fire_d;

    // count while pressed, restart on release, fire once
    always_comb begin
        cnt_d  = cnt_q;
        done_d = done_q;
        fire_d = 1'b0;
        if (sync2_q) begin
            cnt_d  = '0;
            done_d = 1'b0;
        end else if (!done_q) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == HOLD_LIM) begin
                fire_d = 1'b1;
                done_d = 1'b1;
            end
        end
    end

    // two-stage pin sync and timer state
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            cnt_q   <= '0;
            done_q  <= 1'b0;
            fire_q  <= 1'b0;
        end else begin
            sync1_q <= i_freeze_n;
            sync2_q <= sync1_q;
            cnt_q   <= cnt_d;
            done_q  <= done_d;
            fire_q  <= fire_d;
        end
    end

    assign o_fire = fire_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    fire_once_a: assert property (fire_q |=> !fire_q [*2])
        else $error("hold timer fired twice in one press");
    release_clr_a: assert property (sync2_q |=> cnt_q == '0)
        else $error("hold counter not cleared on release");

endmodule // mnu_hold_timer

// File: core/mnu_ctrl.sv
// Purpose: menu mode controller for the cartridge emulation core
// Assumes: cpu bus on i_clk_sys, one strobe per access, config mode from core
// Notes:   all answers come one clock after the strobe
// Contract
// - menu mode active after hardware reset
// - long freeze press enters menu mode
// - command 0x20 in config mode enters menu
// - menu forces io in, port bits ignored
// - overridden config writes apply after menu exit
// - menu forces expansion on, cartridges off
// - seven substitute 8K banks replace memory
// - C000 to CFFF keeps bank 0x0C
// - video uses substitutes, char fetches bank 0x1D
// - video C000 to DFFF uses banks 0C/0D
// - menu without config: others read 0xFF
// - command writes accepted while in menu
// - bit five maps extra area, persists
// - extra area wins over second sound chip
// - config disable reads 0x40 when visible
// - config disable read exits, fetch restores
// - C000 to CFFF mapping unchanged across switch
// - command A5 or A6 soft resets, exits
`timescale 1ns/1ps
`include "mnu_defs.svh"
module mnu_ctrl
    import mnu_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = `MNU_HOLD_CYC
) (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // host cpu bus
    input  wire logic        i_cpu_strobe,
    input  wire logic        i_cpu_rnw,
    input  wire logic        i_cpu_sync,
    input  wire logic [15:0] i_cpu_addr,
    input  wire logic [7:0]  i_cpu_wdata,
    output logic      [7:0]  o_cpu_rdata,
    output logic             o_cpu_rhit,
    // cpu memory map
    input  wire logic        i_port_io,
    output mnu_sel_e         o_cpu_sel,
    output logic      [7:0]  o_cpu_bank,
    output logic             o_cpu_map_vld,
    // video fetch map
    input  wire logic        i_vid_strobe,
    input  wire logic [15:0] i_vid_addr,
    output logic      [7:0]  o_vid_bank,
    output logic             o_vid_subst,
    output logic             o_vid_vld,
    // mode and overrides
    input  wire logic        i_cfg_mode,
    input  wire logic        i_freeze_n,
    output logic             o_menu_active,
    output logic             o_soft_reset,
    output logic      [7:0]  o_cart_mode,
    output logic             o_ramexp_on,
    output logic             o_memcard_on,
    output logic             o_extra_en,
    output logic             o_sid2_block
);

    mnu_state_e menu_q;
    mnu_state_e menu_d;
    logic [7:0] cart_q;
    logic [7:0] cart_d;
    logic [7:0] port_q;
    logic [7:0] port_d;
    logic [7:0] ramexp_q;
    logic [7:0] ramexp_d;
    logic [7:0] extra_q;
    logic [7:0] extra_d;
    logic       srst_q;
    logic       srst_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rhit_q;
    logic       rhit_d;
    mnu_sel_e   sel_q;
    mnu_sel_e   sel_d;
    logic [7:0] bank_q;
    logic [7:0] bank_d;
    logic       map_vld_q;
    logic [7:0] vbank_q;
    logic [7:0] vbank_d;
    logic       vsub_q;
    logic       vsub_d;
    logic       vvld_q;
    logic [7:0] cart_o_q;
    logic       ramexp_o_q;
    logic       memcard_o_q;

    logic       fire;
    logic       in_menu;
    logic       visible;
    logic       rd;
    logic       wr;
    logic       cfgdis_rd;
    logic       cmd_wr;
    logic       menu_eff;
    logic [3:0] nib;
    logic [2:0] idx;
    logic [3:0] vnib;
    logic [2:0] vidx;

    // freeze button hold detection
    mnu_hold_timer #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_hold (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_freeze_n (i_freeze_n),
        .o_fire     (fire)
    );

    // access decode
    assign in_menu   = (menu_q == MNU_ON);
    assign visible   = in_menu | i_cfg_mode;
    assign rd        = i_cpu_strobe & i_cpu_rnw;
    assign wr        = i_cpu_strobe & ~i_cpu_rnw;
    assign cfgdis_rd = rd & (i_cpu_addr == `MNU_REG_CFGDIS);
    assign cmd_wr    = wr & (i_cpu_addr == `MNU_REG_CMD) & visible;
    assign menu_eff  = in_menu & ~(cfgdis_rd & i_cpu_sync);
    assign nib       = i_cpu_addr[15:12];
    assign idx       = i_cpu_addr[15:13];
    assign vnib      = i_vid_addr[15:12];
    assign vidx      = i_vid_addr[15:13];

    // menu state and configuration registers
    always_comb begin
        menu_d   = menu_q;
        cart_d   = cart_q;
        port_d   = port_q;
        ramexp_d = ramexp_q;
        extra_d  = extra_q;
        srst_d   = 1'b0;
        if (cfgdis_rd) begin
            menu_d = MNU_OFF;
        end
        if (cmd_wr && (i_cpu_wdata == `MNU_CMD_RST_A || i_cpu_wdata == `MNU_CMD_RST_B)) begin
            srst_d = 1'b1;
            menu_d = MNU_OFF;
        end
        if (fire || (cmd_wr && i_cpu_wdata == `MNU_CMD_MENU)) begin
            menu_d = MNU_ON;
        end
        if (wr && i_cfg_mode) begin
            unique case (i_cpu_addr)
                `MNU_REG_CART:   cart_d   = i_cpu_wdata;
                `MNU_REG_PORT:   port_d   = i_cpu_wdata;
                `MNU_REG_RAMEXP: ramexp_d = i_cpu_wdata;
                `MNU_REG_EXTRA:  extra_d  = i_cpu_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            menu_q   <= MNU_ON;
            cart_q   <= `MNU_CART_OFF;
            port_q   <= 8'h00;
            ramexp_q <= 8'h00;
            extra_q  <= 8'h00;
            srst_q   <= 1'b0;
        end else begin
            menu_q   <= menu_d;
            cart_q   <= cart_d;
            port_q   <= port_d;
            ramexp_q <= ramexp_d;
            extra_q  <= extra_d;
            srst_q   <= srst_d;
        end
    end

    // read answers and memory map for each strobe
    always_comb begin
        rdata_d = `MNU_READ_IDLE;
        rhit_d  = 1'b0;
        if (rd && i_cpu_addr[15:4] == `MNU_CFG_PAGE && visible) begin
            rhit_d = 1'b1;
            unique case (i_cpu_addr)
                `MNU_REG_STATUS: rdata_d = {5'h00, extra_q[`MNU_EXTRA_BIT],
                                            i_cfg_mode, in_menu};
                `MNU_REG_CFGDIS: rdata_d = `MNU_RTI_OP;
                `MNU_REG_CART:   rdata_d = i_cfg_mode ? cart_q : `MNU_READ_IDLE;
                `MNU_REG_PORT:   rdata_d = i_cfg_mode ? port_q : `MNU_READ_IDLE;
                `MNU_REG_RAMEXP: rdata_d = i_cfg_mode ? ramexp_q : `MNU_READ_IDLE;
                `MNU_REG_EXTRA:  rdata_d = i_cfg_mode ? extra_q : `MNU_READ_IDLE;
                `MNU_REG_CMD:    rdata_d = i_cfg_mode ? `MNU_CORE_VER : `MNU_READ_IDLE;
                default:         rdata_d = `MNU_READ_IDLE;
            endcase
        end
        // cpu side mapping
        sel_d  = MNU_SEL_NORM;
        bank_d = {4'h0, nib};
        if (i_cpu_addr[15:8] == `MNU_EXTRA_PAGE && extra_q[`MNU_EXTRA_BIT]) begin
            sel_d = MNU_SEL_EXTRA;
        end else if (nib == `MNU_IO_NIB && (menu_eff || i_port_io)) begin
            sel_d = MNU_SEL_IO;
        end else if (menu_eff && idx != `MNU_KEEP_IDX) begin
            sel_d  = MNU_SEL_SUBST;
            bank_d = `MNU_SUBST_BASE + {5'h00, idx};
        end
        // video side mapping
        vsub_d  = 1'b0;
        vbank_d = {4'h0, vnib};
        if (in_menu) begin
            if (vnib == `MNU_CHAR_NIB_LO || vnib == `MNU_CHAR_NIB_HI) begin
                vbank_d = `MNU_CHAR_BANK;
            end else if (vidx != `MNU_KEEP_IDX) begin
                vsub_d  = 1'b1;
                vbank_d = `MNU_SUBST_BASE + {5'h00, vidx};
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rdata_q     <= `MNU_READ_IDLE;
            rhit_q      <= 1'b0;
            sel_q       <= MNU_SEL_NORM;
            bank_q      <= 8'h00;
            map_vld_q   <= 1'b0;
            vbank_q     <= 8'h00;
            vsub_q      <= 1'b0;
            vvld_q      <= 1'b0;
            cart_o_q    <= `MNU_CART_OFF;
            ramexp_o_q  <= 1'b0;
            memcard_o_q <= 1'b0;
        end else begin
            rdata_q     <= rdata_d;
            rhit_q      <= rhit_d;
            map_vld_q   <= i_cpu_strobe;
            vvld_q      <= i_vid_strobe;
            if (i_cpu_strobe) begin
                sel_q  <= sel_d;
                bank_q <= bank_d;
            end
            if (i_vid_strobe) begin
                vbank_q <= vbank_d;
                vsub_q  <= vsub_d;
            end
            // overrides while in menu, stored values afterwards
            cart_o_q    <= in_menu ? `MNU_CART_OFF : cart_q;
            ramexp_o_q  <= in_menu | ramexp_q[`MNU_RAMEXP_BIT];
            memcard_o_q <= in_menu | port_q[`MNU_MEMCARD_BIT];
        end
    end

    // outputs straight from flip-flops
    assign o_cpu_rdata   = rdata_q;
    assign o_cpu_rhit    = rhit_q;
    assign o_cpu_sel     = sel_q;
    assign o_cpu_bank    = bank_q;
    assign o_cpu_map_vld = map_vld_q;
    assign o_vid_bank    = vbank_q;
    assign o_vid_subst   = vsub_q;
    assign o_vid_vld     = vvld_q;
    assign o_menu_active = menu_q;
    assign o_soft_reset  = srst_q;
    assign o_cart_mode   = cart_o_q;
    assign o_ramexp_on   = ramexp_o_q;
    assign o_memcard_on  = memcard_o_q;
    assign o_extra_en    = extra_q[`MNU_EXTRA_BIT];
    assign o_sid2_block  = extra_q[`MNU_EXTRA_BIT];

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    reset_menu_on_a: assert property ($past(i_rst) && !i_rst |-> menu_q == MNU_ON)
        else $error("menu not active after reset");
    freeze_entry_a: assert property (fire |=> menu_q == MNU_ON)
        else $error("long press did not enter menu");
    cmd_entry_a: assert property (wr && i_cfg_mode && i_cpu_addr == `MNU_REG_CMD
        && i_cpu_wdata == `MNU_CMD_MENU |=> menu_q == MNU_ON)
        else $error("menu command ignored");
    io_forced_a: assert property (i_cpu_strobe && in_menu && !cfgdis_rd
        && nib == `MNU_IO_NIB && !extra_q[`MNU_EXTRA_BIT] |=> sel_q == MNU_SEL_IO)
        else $error("io not forced in menu");
    held_cfg_a: assert property (menu_q == MNU_OFF ##1 menu_q == MNU_OFF
        |-> cart_o_q == $past(cart_q))
        else $error("held setting not applied after exit");
    menu_force_a: assert property (in_menu |=> cart_o_q == `MNU_CART_OFF
        && ramexp_o_q && memcard_o_q)
        else $error("menu overrides missing");
    subst_map_a: assert property (i_cpu_strobe && menu_eff && nib < `MNU_C_NIB
        |=> sel_q == MNU_SEL_SUBST && bank_q >= `MNU_SUBST_BASE)
        else $error("substitute bank not selected");
    keep_c_a: assert property (i_cpu_strobe && nib == `MNU_C_NIB
        |=> sel_q == MNU_SEL_NORM && bank_q == {4'h0, `MNU_C_NIB})
        else $error("C page lost its bank");
    char_fetch_a: assert property (i_vid_strobe && in_menu && vnib == `MNU_CHAR_NIB_HI
        |=> vbank_q == `MNU_CHAR_BANK && !vsub_q)
        else $error("char fetch not on char bank");
    vid_c_a: assert property (i_vid_strobe && vidx == `MNU_KEEP_IDX
        |=> vbank_q == {4'h0, $past(vnib)} && !vsub_q)
        else $error("video C/D page remapped");
    menu_ff_a: assert property (rd && in_menu && !i_cfg_mode && i_cpu_addr == `MNU_REG_CART
        |=> rhit_q && rdata_q == `MNU_READ_IDLE)
        else $error("hidden register readable");
    rti_read_a: assert property (cfgdis_rd && visible |=> rdata_q == `MNU_RTI_OP)
        else $error("config disable not 0x40");
    exit_read_a: assert property (cfgdis_rd && !fire |=> menu_q == MNU_OFF)
        else $error("read did not leave menu");
    soft_reset_a: assert property (cmd_wr && i_cpu_wdata == `MNU_CMD_RST_A && !fire
        |=> srst_q && menu_q == MNU_OFF ##1 (!srst_q || $past(cmd_wr)))
        else $error("soft reset not a single pulse");

    cover_freeze_c: cover property (menu_q == MNU_OFF ##1 fire ##1 menu_q == MNU_ON);
    cover_rti_c: cover property (in_menu && cfgdis_rd && i_cpu_sync);
    cover_srst_c: cover property (srst_q);
    cover_extra_c: cover property (map_vld_q && sel_q == MNU_SEL_EXTRA);

endmodule // mnu_ctrl

// File: dv/mnu_cpu_model.sv
// Purpose: host cpu model issuing single byte accesses
// Assumes: one strobe per access, answer registered one clock later
// Notes:   released address and data lines carry the inverted last value
`timescale 1ns/1ps
module mnu_cpu_model (
    // clock
    input  wire logic        i_clk_sys,
    // cpu bus requests
    output logic             o_strobe,
    output logic             o_rnw,
    output logic             o_sync,
    output logic      [15:0] o_addr,
    output logic      [7:0]  o_wdata,
    // answer
    input  wire logic [7:0]  i_rdata,
    input  wire logic        i_rhit
);
    logic [7:0] rd_q;
    logic       rhit_q;

    // idle bus at time zero
    initial begin
        o_strobe = 1'b0;
        o_rnw    = 1'b1;
        o_sync   = 1'b0;
        o_addr   = 16'h0000;
        o_wdata  = 8'h00;
    end

    // one access: strobe for one cycle, answer taken after the next edge
    task automatic acc(input logic rnw, input logic sy, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge i_clk_sys);
        o_strobe <= 1'b1;
        o_rnw    <= rnw;
        o_sync   <= sy;
        o_addr   <= a;
        o_wdata  <= d;
        @(posedge i_clk_sys);
        o_strobe <= 1'b0;
        o_sync   <= 1'b0;
        o_addr   <= ~a;
        o_wdata  <= ~d;
        #1;
        rd_q   = i_rdata;
        rhit_q = i_rhit;
    endtask

    // leave the menu by fetching the return opcode; stack already laid out
    task automatic ret_fetch();
        acc(1'b1, 1'b1, 16'hD0FF, 8'h00);
    endtask
endmodule // mnu_cpu_model

// File: dv/mnu_ctrl_tb_top.sv
// Purpose: self-checking bench of the menu mode controller
// Assumes: short hold count, cpu model drives the bus
// Notes:   each scenario task judges its own results
`timescale 1ns/1ps
`include "mnu_defs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module mnu_ctrl_tb_top import mnu_pkg::*; ();
    localparam int HOLD = 20;
    logic        i_clk_sys = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_cpu_strobe, i_cpu_rnw, i_cpu_sync;
    logic [15:0] i_cpu_addr;
    logic [7:0]  i_cpu_wdata, o_cpu_rdata, o_vid_bank, o_cpu_bank, o_cart_mode;
    logic        o_cpu_rhit, o_cpu_map_vld, o_vid_subst, o_vid_vld;
    logic        i_port_io = 1'b0;
    logic        i_vid_strobe = 1'b0;
    logic [15:0] i_vid_addr = 16'h0000;
    logic        i_cfg_mode = 1'b0;
    logic        i_freeze_n = 1'b1;
    logic        o_menu_active, o_soft_reset, o_ramexp_on, o_memcard_on;
    logic        o_extra_en, o_sid2_block;
    mnu_sel_e    o_cpu_sel;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          n;

    // clock generation
    always #2.5 i_clk_sys = ~i_clk_sys;

    mnu_ctrl #(.HOLD_CYCLES(HOLD)) i_mnu_ctrl (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cpu_strobe(i_cpu_strobe),
        .i_cpu_rnw(i_cpu_rnw), .i_cpu_sync(i_cpu_sync), .i_cpu_addr(i_cpu_addr),
        .i_cpu_wdata(i_cpu_wdata), .o_cpu_rdata(o_cpu_rdata), .o_cpu_rhit(o_cpu_rhit),
        .i_port_io(i_port_io), .o_cpu_sel(o_cpu_sel), .o_cpu_bank(o_cpu_bank),
        .o_cpu_map_vld(o_cpu_map_vld), .i_vid_strobe(i_vid_strobe),
        .i_vid_addr(i_vid_addr), .o_vid_bank(o_vid_bank), .o_vid_subst(o_vid_subst),
        .o_vid_vld(o_vid_vld), .i_cfg_mode(i_cfg_mode), .i_freeze_n(i_freeze_n),
        .o_menu_active(o_menu_active), .o_soft_reset(o_soft_reset),
        .o_cart_mode(o_cart_mode), .o_ramexp_on(o_ramexp_on),
        .o_memcard_on(o_memcard_on), .o_extra_en(o_extra_en),
        .o_sid2_block(o_sid2_block));

    mnu_cpu_model i_mnu_cpu_model (
        .i_clk_sys(i_clk_sys), .o_strobe(i_cpu_strobe), .o_rnw(i_cpu_rnw),
        .o_sync(i_cpu_sync), .o_addr(i_cpu_addr), .o_wdata(i_cpu_wdata),
        .i_rdata(o_cpu_rdata), .i_rhit(o_cpu_rhit));

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // cycle ceiling against hangs
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic rd(input logic [15:0] a);
        i_mnu_cpu_model.acc(1'b1, 1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_mnu_cpu_model.acc(1'b0, 1'b0, a, d);
    endtask
    task automatic vid(input logic [15:0] a);
        @(posedge i_clk_sys);
        i_vid_strobe <= 1'b1;
        i_vid_addr   <= a;
        @(posedge i_clk_sys);
        i_vid_strobe <= 1'b0;
        i_vid_addr   <= ~a;
        #1;
    endtask

    // cpu and video map while the menu is up, io bits saying off
    task automatic t_menu_map();
        rd(16'h1234);
        `CHK("map_vld", 1'b1, o_cpu_map_vld)
        `CHK("sel_sub", MNU_SEL_SUBST, o_cpu_sel)
        `CHK("bank_sub0", 8'h20, o_cpu_bank)
        rd(16'hE000);
        `CHK("bank_sub7", 8'h27, o_cpu_bank)
        rd(16'hC123);
        `CHK("sel_c", MNU_SEL_NORM, o_cpu_sel)
        `CHK("bank_c", 8'h0C, o_cpu_bank)
        rd(16'hD020);
        `CHK("sel_io", MNU_SEL_IO, o_cpu_sel)
        rd(`MNU_REG_STATUS);
        `CHK("stat", 9'h101, {i_mnu_cpu_model.rhit_q, i_mnu_cpu_model.rd_q})
        rd(`MNU_REG_CART);
        `CHK("hide_cart", 8'hFF, o_cpu_rdata)
        rd(`MNU_REG_CMD);
        `CHK("hide_cmd", 8'hFF, o_cpu_rdata)
        vid(16'h9123);
        `CHK("vid_vld", 1'b1, o_vid_vld)
        `CHK("vid_chr_hi", 9'h01D, {o_vid_subst, o_vid_bank})
        vid(16'h1000);
        `CHK("vid_chr_lo", 9'h01D, {o_vid_subst, o_vid_bank})
        vid(16'h4000);
        `CHK("vid_sub", 9'h122, {o_vid_subst, o_vid_bank})
        vid(16'hC000);
        `CHK("vid_c", 9'h00C, {o_vid_subst, o_vid_bank})
        vid(16'hD000);
        `CHK("vid_d", 9'h00D, {o_vid_subst, o_vid_bank})
    endtask

    // leave through the return opcode fetch, then the normal map
    task automatic t_exit();
        i_mnu_cpu_model.ret_fetch();
        `CHK("rti_op", `MNU_RTI_OP, i_mnu_cpu_model.rd_q)
        `CHK("exit", 1'b0, o_menu_active)
        `CHK("fetch_map", MNU_SEL_NORM, o_cpu_sel)
        rd(16'h1234);
        `CHK("bank_norm", 8'h01, o_cpu_bank)
        rd(16'hC123);
        `CHK("bank_c_keep", 8'h0C, o_cpu_bank)
        rd(16'hD020);
        `CHK("port_off", 8'h0D, o_cpu_bank)
        rd(`MNU_REG_STATUS);
        `CHK("stat_off", 9'h0FF, {o_cpu_rhit, o_cpu_rdata})
        wr(`MNU_REG_CMD, `MNU_CMD_MENU);
        `CHK("cmd_refused", 1'b0, o_menu_active)
        vid(16'h4000);
        `CHK("vid_norm", 1'b0, o_vid_subst)
    endtask

    // settings made outside the menu, held writes inside it
    task automatic t_cfg();
        @(posedge i_clk_sys) i_cfg_mode <= 1'b1;
        i_port_io <= 1'b1;
        // cartridge setting changed only outside the menu
        wr(`MNU_REG_CART, 8'h01);
        wr(`MNU_REG_PORT, 8'h00);
        wr(`MNU_REG_RAMEXP, 8'h00);
        wr(`MNU_REG_EXTRA, 8'h20);
        `CHK("pre_ovr", 11'h008, {o_cart_mode, o_ramexp_on, o_memcard_on, 1'b0})
        `CHK("extra_on", 2'b11, {o_extra_en, o_sid2_block})
        rd(`MNU_REG_CFGDIS);
        `CHK("cfg_rti", `MNU_RTI_OP, i_mnu_cpu_model.rd_q)
        wr(`MNU_REG_CMD, `MNU_CMD_MENU);
        `CHK("cmd_menu", 1'b1, o_menu_active)
        wr(`MNU_REG_RAMEXP, 8'h80);
        wr(`MNU_REG_PORT, 8'h04);
        `CHK("ovr_on", 10'h003, {o_cart_mode, o_ramexp_on, o_memcard_on})
        @(posedge i_clk_sys) i_cfg_mode <= 1'b0;
        rd(16'hD710);
        `CHK("extra_menu", MNU_SEL_EXTRA, o_cpu_sel)
        rd(`MNU_REG_CFGDIS);
        `CHK("exit_load", 1'b0, o_menu_active)
        @(posedge i_clk_sys);
        #1;
        `CHK("held", 10'h007, {o_cart_mode, o_ramexp_on, o_memcard_on})
        rd(16'hD710);
        `CHK("extra_stays", MNU_SEL_EXTRA, o_cpu_sel)
        rd(16'hD020);
        `CHK("port_io", MNU_SEL_IO, o_cpu_sel)
    endtask

    // long and short presses, then both soft reset codes
    task automatic t_freeze();
        @(posedge i_clk_sys) i_freeze_n <= 1'b0;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end while (o_menu_active !== 1'b1 && n < 40);
        `CHK("hold_min", 1'b1, n > HOLD)
        `CHK("hold_max", 1'b1, n <= HOLD + 6)
        rd(`MNU_REG_CFGDIS);
        repeat (40) @(posedge i_clk_sys);
        #1;
        `CHK("once", 1'b0, o_menu_active)
        @(posedge i_clk_sys) i_freeze_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        i_freeze_n <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        i_freeze_n <= 1'b1;
        repeat (30) @(posedge i_clk_sys);
        #1;
        `CHK("short", 1'b0, o_menu_active)
        @(posedge i_clk_sys) i_freeze_n <= 1'b0;
        repeat (HOLD + 8) @(posedge i_clk_sys);
        i_freeze_n <= 1'b1;
        #1;
        `CHK("again", 1'b1, o_menu_active)
        wr(`MNU_REG_CMD, `MNU_CMD_RST_A);
        `CHK("rst_a", 2'b10, {o_soft_reset, o_menu_active})
        @(posedge i_clk_sys) i_cfg_mode <= 1'b1;
        wr(`MNU_REG_CMD, `MNU_CMD_MENU);
        @(posedge i_clk_sys) i_cfg_mode <= 1'b0;
        wr(`MNU_REG_CMD, `MNU_CMD_RST_B);
        `CHK("rst_b", 2'b10, {o_soft_reset, o_menu_active})
        @(posedge i_clk_sys);
        #1;
        `CHK("rst_pulse", 1'b0, o_soft_reset)
    endtask

    // reset again in mid-run
    task automatic t_rst2();
        @(posedge i_clk_sys) i_rst <= 1'b1;
        #1;
        `CHK("rst_menu", 1'b1, o_menu_active)
        repeat (3) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        `CHK("rst_ovr", 2'b11, {o_ramexp_on, o_memcard_on})
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge i_clk_sys);
        #1;
        `CHK("por_menu", 1'b1, o_menu_active)
        @(posedge i_clk_sys) i_rst <= 1'b0;
        t_menu_map();
        t_exit();
        t_cfg();
        t_freeze();
        t_rst2();
        summarize();
    end
endmodule // mnu_ctrl_tb_top
